/* verilog/fdp_pkg.sv */
// package: register layout, reset values and carriers for phase control
package fdp_pkg;
  // byte addresses of the register; the phase register sits at 0x8
  localparam logic [3:0]  ADDR_W             = 4'h4;
  localparam logic [3:0]  PHASE_CFG_LO_ADDR  = 4'h8;
  localparam logic [3:0]  PHASE_CFG_HI_ADDR  = 4'h9;
  localparam logic [3:0]  STATUS_ADDR        = 4'hC;
  // field positions inside the 16-bit register
  localparam int          APPLY_NOW_BIT      = 15;
  localparam int          APPLY_SYNC_BIT     = 14;
  localparam int          SLOW_FREQ_BIT      = 13;
  localparam int          PHASE_MSB          = 9;
  // reset values
  localparam logic [9:0]  PHASE_RESET        = 10'h3F0;
  localparam logic        APPLY_SYNC_RESET   = 1'b1;
  localparam logic        SLOW_FREQ_RESET    = 1'b0;
  // slot indices of the tiny staging memory
  localparam logic [0:0]  SLOT_STAGED        = 1'h0;
  localparam logic [0:0]  SLOT_COMMITTED     = 1'h1;

  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } fdp_bus_req_t;

  // phase request towards the divider
  typedef struct packed {
    logic        valid;
    logic [9:0]  offset;
  } fdp_phase_req_t;
endpackage : fdp_pkg

/* verilog/fdp_phase_store.sv */
// two-slot phase store with registered read port
`timescale 1ns/100ps
`default_nettype none
module fdp_phase_store (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        we_in,
  input  wire logic [0:0]  waddr_in,
  input  wire logic [9:0]  wdata_in,
  input  wire logic [0:0]  raddr_in,
  output logic      [9:0]  rdata_out
);
  logic [9:0] mem [2];

  // both slots come out of reset at the documented offset
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      mem[0] <= fdp_pkg::PHASE_RESET;
      mem[1] <= fdp_pkg::PHASE_RESET;
    end
    else if (we_in)
      mem[waddr_in] <= wdata_in;
  end

  // registered read; bypass keeps a same-cycle write visible next cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      rdata_out <= fdp_pkg::PHASE_RESET;
    else if (we_in && waddr_in == raddr_in)
      rdata_out <= wdata_in;
    else
      rdata_out <= mem[raddr_in];
  end
endmodule : fdp_phase_store
`default_nettype wire

/* verilog/fdp_phase_ctrl.sv */
// phase offset control register bank for the fractional output divider
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - phase offset is signed quarter-period steps
// - phase offset resets to 0x3F0
// - offset commits on write of top byte
// - writing apply-now one applies committed offset
// - apply-now holds until adjustment completes
// - apply-on-sync applies offset at each sync that arrives while idle
module fdp_phase_ctrl (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_n_in,
  input  wire fdp_pkg::fdp_bus_req_t  bus_in,
  output logic [7:0]                  rdata_out,
  input  wire logic                   div_sync_in,
  input  wire logic                   adj_done_in,
  output fdp_pkg::fdp_phase_req_t     phase_req_out,
  output logic                        adj_busy_out,
  output logic                        slow_freq_en_out
);
  typedef enum logic [1:0] {FDP_IDLE, FDP_LOAD, FDP_WAIT} fdp_state_t;

  fdp_state_t  state;
  logic [7:0]  staged_lo;
  logic [1:0]  staged_hi;
  logic        apply_now;
  logic        apply_sync;
  logic        slow_en;
  logic        now_req;
  logic        sync_req;
  logic        now_pend;
  logic        commit;
  logic [9:0]  store_wdata;
  logic [9:0]  committed;

  // register layout, one byte per address:
  //   low byte  - offset bits 7:0, staged until the high byte lands
  //   high byte - bit 7 apply-now, bit 6 apply-on-sync, bit 5 slow enable,
  //               bits 4:2 reserved and never stored, bits 1:0 offset 9:8
  //   status    - bits 2:1 committed offset 9:8, bit 0 sequencer active
  // software writes the low byte first and the high byte last; a high
  // byte written alone re-commits the old low byte with new top bits,
  // which is legal but rarely what is wanted
  // the offset is signed in quarter vco periods; the reset value sits
  // sixteen steps early so an integer ratio starts out lined up with
  // the integer output divider
  // a held apply-now costs one flop but keeps every 0->1 write honoured

  // sequencer activity, read by busy, status and the held request
  function automatic logic is_active(input fdp_state_t s);
    is_active = (s != FDP_IDLE);
  endfunction : is_active

  // byte-wide register write decode
  // one compare per address keeps the decode in one place
  function automatic logic hit(input fdp_pkg::fdp_bus_req_t r,
                               input logic [3:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // writing the byte with bits 9:8 is the commit point
  assign commit      = hit(bus_in, fdp_pkg::PHASE_CFG_HI_ADDR);
  assign store_wdata = {bus_in.wdata[1:0], staged_lo};

  // low byte is only staged; the divider never sees a half-written value
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      staged_lo <= fdp_pkg::PHASE_RESET[7:0];
    else if (hit(bus_in, fdp_pkg::PHASE_CFG_LO_ADDR))
      staged_lo <= bus_in.wdata;
  end

  // top two bits kept for readback of the staged word
  // they change only together with the commit, never on their own
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      staged_hi <= fdp_pkg::PHASE_RESET[9:8];
    else if (commit)
      staged_hi <= bus_in.wdata[1:0];
  end

  // committed offset lives in the store, slot one
  // slot zero is spare; the store keeps the read registered so the
  // apply pulse and its offset both launch from flops
  fdp_phase_store u_store (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .we_in      (commit),
    .waddr_in   (fdp_pkg::SLOT_COMMITTED),
    .wdata_in   (store_wdata),
    .raddr_in   (fdp_pkg::SLOT_COMMITTED),
    .rdata_out  (committed)
  );

  // control bits; bits 12:10 are not stored at all
  // the top-byte write is the only place these bits change
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      apply_sync <= fdp_pkg::APPLY_SYNC_RESET;
      slow_en    <= fdp_pkg::SLOW_FREQ_RESET;
    end
    else if (commit)
    begin
      apply_sync <= bus_in.wdata[fdp_pkg::APPLY_SYNC_BIT - 8];
      slow_en    <= bus_in.wdata[fdp_pkg::SLOW_FREQ_BIT - 8];
    end
  end

  // 0->1 write of apply-now requests an adjustment
  assign now_req  = commit && bus_in.wdata[fdp_pkg::APPLY_NOW_BIT - 8]
                    && !apply_now;
  assign sync_req = div_sync_in && apply_sync;

  // a 0->1 write of apply-now that lands while a sync adjustment runs is
  // held here and launched once the sequencer is idle again, so the
  // request is never silently lost
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      now_pend <= 1'b0;
    else if (now_req && is_active(state))
      now_pend <= 1'b1;
    else if (!is_active(state))
      now_pend <= 1'b0;
  end

  // apply sequencer; LOAD waits one cycle so the store read settles
  // sync events that arrive while busy are dropped; only apply-now is
  // held, since software expects its own write to take effect
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      state <= FDP_IDLE;
    else
      case (state)
        FDP_IDLE:
          if (now_req || sync_req || now_pend)
            state <= FDP_LOAD;
        FDP_LOAD:
          state <= FDP_WAIT;
        FDP_WAIT:
          if (adj_done_in)
            state <= FDP_IDLE;
        default:
          state <= FDP_IDLE;
      endcase
  end

  // apply-now self-clears; writing zero never clears it early
  // it stays up while a held request still has to run
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      apply_now <= 1'b0;
    else if (now_req)
      apply_now <= 1'b1;
    else if (state == FDP_WAIT && adj_done_in && !now_pend)
      apply_now <= 1'b0;
  end

  // one-cycle apply pulse carrying the signed quarter-step offset
  // the offset follows the committed value every cycle; the divider
  // only takes it while valid is high
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      phase_req_out <= '0;
    else
    begin
      phase_req_out.valid  <= (state == FDP_LOAD);
      phase_req_out.offset <= committed;
    end
  end

  // busy rises with the request itself, so software polling right after
  // the write never sees a gap before the sequencer leaves idle
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      adj_busy_out <= 1'b0;
    else
      adj_busy_out <= is_active(state) || now_req || sync_req || now_pend;
  end

  // slow enable mirrored to a flop so the pin never glitches
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      slow_freq_en_out <= fdp_pkg::SLOW_FREQ_RESET;
    else
      slow_freq_en_out <= slow_en;
  end

  // read data one cycle after the strobe, zero otherwise
  // reads have no side effects, so software may poll freely
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else if (!bus_in.rd)
      rdata_out <= 8'h00;
    else
      case (bus_in.addr)
        fdp_pkg::PHASE_CFG_LO_ADDR:
          rdata_out <= staged_lo;
        fdp_pkg::PHASE_CFG_HI_ADDR:
          rdata_out <= {apply_now, apply_sync, slow_en, 3'h0,
                        staged_hi};
        fdp_pkg::STATUS_ADDR:
          rdata_out <= {5'h00, committed[9:8],
                        is_active(state)};
        default:
          rdata_out <= 8'h00;
      endcase
  end
endmodule : fdp_phase_ctrl
`default_nettype wire

/* verif/fdp_phase_ctrl_assertions.sv */
// checker for the phase control register bank
`timescale 1ns/100ps
`default_nettype none
module fdp_chk (
  input wire logic                    sys_clk_in,
  input wire logic                    rst_n_in,
  input wire fdp_pkg::fdp_bus_req_t   bus_in,
  input wire logic [7:0]              rdata_out,
  input wire logic                    div_sync_in,
  input wire logic                    adj_done_in,
  input wire fdp_pkg::fdp_phase_req_t phase_req_out,
  input wire logic                    adj_busy_out,
  input wire logic                    slow_freq_en_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic      sb;
  wire logic hi_wr = bus_in.wr && bus_in.addr == 4'h9;
  // shadow of the apply-on-sync bit, so sync checks know the mode
  always_ff @(posedge sys_clk_in)
    if (!rst_n_in)
      sb <= 1'b1;
    else if (hi_wr)
      sb <= bus_in.wdata[6];
  sequence s_now;
    hi_wr && bus_in.wdata[7] && !adj_busy_out;
  endsequence
  sequence s_sync;
    div_sync_in && sb && !adj_busy_out;
  endsequence
  // a_reset_val: offset rests at -16 quarter steps
  a_reset_val: assert property (
    $rose(rst_n_in) |-> ##1 phase_req_out.offset == 10'h3F0)
    else $error("reset offset wrong");
  a_commit_hi: assert property (
    $past(rst_n_in, 3) && $changed(phase_req_out.offset)
    |-> $past(hi_wr, 2))
    else $error("offset moved without top byte");
  a_now_apply: assert property (
    s_now |-> ##2 phase_req_out.valid)
    else $error("apply now missed");
  // busy may only fall two cycles after the divider reported done
  a_busy_hold: assert property (
    $fell(adj_busy_out) |-> $past(adj_done_in, 2))
    else $error("busy dropped early");
  a_valid_once: assert property (
    phase_req_out.valid |-> adj_busy_out ##1 !phase_req_out.valid)
    else $error("apply pulse bad");
  a_sync_apply: assert property (
    s_sync |-> ##2 phase_req_out.valid)
    else $error("sync apply missed");
  a_sync_off: assert property (
    div_sync_in && !sb && !adj_busy_out && !hi_wr
    |-> ##2 !phase_req_out.valid)
    else $error("sync applied while off");
  a_rsvd_zero: assert property (
    bus_in.rd && bus_in.addr == 4'h9 |=> rdata_out[4:2] == 3'h0)
    else $error("reserved bits set");
endmodule : fdp_chk
bind fdp_phase_ctrl fdp_chk u_chk (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .div_sync_in(div_sync_in), .adj_done_in(adj_done_in),
  .phase_req_out(phase_req_out), .adj_busy_out(adj_busy_out),
  .slow_freq_en_out(slow_freq_en_out));
`default_nettype wire

/* verif/fdp_phase_ctrl_tb.sv */
// self-checking bench for the phase control register bank
`timescale 1ns/100ps
`default_nettype none
module fdp_phase_ctrl_tb;
  logic                    sys_clk_in, rst_n_in, div_sync_in, adj_done_in;
  fdp_pkg::fdp_bus_req_t   bus;
  logic [7:0]              rdata;
  fdp_pkg::fdp_phase_req_t req;
  logic                    busy, slow;
  int                      n_mismatch, n_tests, i;
  // rows: address, write byte, expected read back
  logic [19:0] rows [5] = '{20'h95F43, 20'h92222, 20'h8A5A5, 20'h4FF00,
                            20'h94040};
  fdp_phase_ctrl dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .bus_in(bus), .rdata_out(rdata), .div_sync_in(div_sync_in),
    .adj_done_in(adj_done_in), .phase_req_out(req),
    .adj_busy_out(busy), .slow_freq_en_out(slow));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic ck(input logic ok);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR %0t check %0d failed", $time, n_tests);
    end
  endtask : ck
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // one-cycle bus strobes, launched just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    bus.rd <= 1'b0;
    #1 ck(rdata === e);
  endtask : rd
  task automatic sync_pulse;
    @(posedge sys_clk_in);
    div_sync_in <= 1'b1;
    @(posedge sys_clk_in);
    div_sync_in <= 1'b0;
  endtask : sync_pulse
  task automatic done_pulse;
    @(posedge sys_clk_in);
    adj_done_in <= 1'b1;
    @(posedge sys_clk_in);
    adj_done_in <= 1'b0;
  endtask : done_pulse
  // bounded look for the apply pulse; a result other than exp counts as a mismatch
  task automatic wait_valid(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (6)
    begin
      @(posedge sys_clk_in);
      #1 seen = seen | (req.valid === 1'b1);
    end
    ck(seen === exp);
  endtask : wait_valid
  initial
  begin
    rst_n_in = 1'b0;
    div_sync_in = 1'b0;
    adj_done_in = 1'b0;
    bus = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    #1 ck(req === '0 && busy === 1'b0 && rdata === 8'h00);
    @(posedge sys_clk_in);
    #1 ck(req.offset === 10'h3F0 && slow === 1'b0);
    rd(4'h9, 8'h43);
    rd(4'h8, 8'hF0);
    for (i = 0; i < 5; i++)
    begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0]);
    end
    wr(4'h8, 8'h05);
    #1 ck(req.offset === 10'h0A5);
    wr(4'h9, 8'h80);
    wait_valid(1'b1);
    ck(req.offset === 10'h005);
    rd(4'h9, 8'h80);
    rd(4'hC, 8'h01);
    ck(busy === 1'b1);
    done_pulse();
    repeat (3) @(posedge sys_clk_in);
    #1 ck(busy === 1'b0);
    rd(4'h9, 8'h00);
    sync_pulse();
    wait_valid(1'b0);
    wr(4'h9, 8'h63);
    sync_pulse();
    wait_valid(1'b1);
    ck(req.offset === 10'h305);
    ck(slow === 1'b1);
    rd(4'hC, 8'h07);
    // apply-now written while a sync adjustment runs is held, not lost
    wr(4'h9, 8'hE3);
    done_pulse();
    wait_valid(1'b1);
    rd(4'h9, 8'hE3);
    done_pulse();
    repeat (2) @(posedge sys_clk_in);
    rd(4'h9, 8'h63);
    // second reset with the sequencer idle restores the reset offset and control bits
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 ck(req.offset === 10'h3F0 && busy === 1'b0);
    rd(4'h9, 8'h43);
    end_sim();
  end
endmodule : fdp_phase_ctrl_tb
`default_nettype wire
